// *** core/dsq_pkg.sv ***
// constants, types and register layout of the dac sequencer output unit
// Overview of operation
// - early frame trigger sets frame error, stops
// - too-fast conversion pulse sets timing error, stops
// - conversion without full preload sets data error
// - error flags held until unit disabled
// - normal mode: active set on start, cleared at count
// - frame mode: active per trigger, kept when continuous
// - preloaded only when all channels hold data
// - preloaded cleared by conversion or invalidate
// - status bit zero shows output unit idle
// - 28-bit read/write count, reset zero
// - normal mode: count per start, zero continuous
// - normal mode: stop at count until start
// - frame mode: count per trigger, then wait
// - frame mode: zero count converts continuously
// - all channels of all dacs update together
// - preload begins after each conversion event
// - preload starts even with incomplete data
// - four values per dac per event
// - mode bit selects normal or frame mode
// - enable must precede the start bit
// - invalidate bit unloads dacs, preload restarts
package dsq_pkg;

  // register byte offsets
  localparam logic [11:0] DSQ_CTRL_OFS = 12'h2E8;
  localparam logic [11:0] DSQ_STATUS_OFS = 12'h2EC;
  localparam logic [11:0] DSQ_NUMCONV_OFS = 12'h2F4;

  // control register fields
  localparam int DSQ_CTRL_ENABLE_BIT = 0;
  localparam int DSQ_CTRL_MODE_BIT = 2;
  localparam int DSQ_CTRL_START_BIT = 3;
  localparam int DSQ_CTRL_PRLD_CLR_BIT = 4;

  // status register fields
  localparam int DSQ_ST_FRAME_ERR_BIT = 6;
  localparam int DSQ_ST_TIME_ERR_BIT = 5;
  localparam int DSQ_ST_DATA_ERR_BIT = 4;
  localparam int DSQ_ST_ACTIVE_BIT = 2;
  localparam int DSQ_ST_PRELOADED_BIT = 1;
  localparam int DSQ_ST_IDLE_BIT = 0;

  // conversions-per-request field
  localparam int DSQ_NUMCONV_W = 28;
  localparam logic [27:0] DSQ_NUMCONV_RESET = 28'h0000000;

  // dac arrangement
  localparam int DSQ_NUM_DACS = 2;
  localparam int DSQ_CH_PER_DAC = 4;
  localparam int DSQ_VALS_PER_EVENT = DSQ_NUM_DACS * DSQ_CH_PER_DAC;
  localparam int DSQ_IDX_W = 3;
  localparam int DSQ_DEV_W = 1;
  localparam int DSQ_DATA_W = 16;
  localparam logic [2:0] DSQ_LAST_IDX = 3'h7;

  // least spacing of two conversion pulses the dacs accept
  localparam int DSQ_CLK_PERIOD_NS = 20;
  localparam int DSQ_MIN_SPACING_NS = 1000;
  localparam int DSQ_MIN_SPACING_CYC =
    (DSQ_MIN_SPACING_NS + DSQ_CLK_PERIOD_NS - 1) / DSQ_CLK_PERIOD_NS;
  localparam int DSQ_SPACE_W = 8;
  localparam logic [7:0] DSQ_MIN_SPACING = 8'(DSQ_MIN_SPACING_CYC);

  // axi responses
  localparam logic [1:0] DSQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] DSQ_RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {DSQ_IDLE, DSQ_ARMED, DSQ_RUN} dsq_state_t;

  // complete state of the output unit and its bus slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic enable;
    logic mode;
    logic [27:0] num_conv;
    dsq_state_t state;
    logic frame_err;
    logic time_err;
    logic data_err;
    logic active;
    logic preloaded;
    logic [2:0] load_idx;
    logic [27:0] conv_cnt;
    logic [7:0] spacing;
    logic fifo_ready;
    logic dac_wr_valid;
    logic [0:0] dac_wr_dev;
    logic [1:0] dac_wr_ch;
    logic [15:0] dac_wr_data;
    logic dac_convert;
  } dsq_regs_t;

  localparam dsq_regs_t DSQ_REGS_RESET = '{
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    state: DSQ_IDLE,
    num_conv: DSQ_NUMCONV_RESET,
    default: '0
  };

endpackage

// *** core/dsq_output_unit.sv ***
// dac sequencer output unit with axi4-lite status and count registers
`timescale 1ns/1ps
module dsq_output_unit
  import dsq_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic conv_clk_event, // one-cycle conversion clock event
  input wire logic frame_trigger, // one-cycle frame trigger event
  input wire logic fifo_valid, // sequencer fifo has a value
  input wire logic [15:0] fifo_data, // sequencer fifo value
  output logic fifo_ready, // unit takes the fifo value
  output logic dac_wr_valid, // one-cycle preload write to a dac
  output logic [0:0] dac_wr_dev, // dac device of the preload write
  output logic [1:0] dac_wr_ch, // dac channel of the preload write
  output logic [15:0] dac_wr_data, // preload value
  output logic dac_convert // one-cycle simultaneous conversion pulse
);

  dsq_regs_t s;
  dsq_regs_t next_s;

  logic start_req;
  logic clr_req;
  logic any_err;
  logic [31:0] status_word;
  logic [27:0] cnt_plus;

  // status word as software sees it
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[DSQ_ST_FRAME_ERR_BIT] = s.frame_err;
    status_word[DSQ_ST_TIME_ERR_BIT] = s.time_err;
    status_word[DSQ_ST_DATA_ERR_BIT] = s.data_err;
    status_word[DSQ_ST_ACTIVE_BIT] = s.active;
    status_word[DSQ_ST_PRELOADED_BIT] = s.preloaded;
    status_word[DSQ_ST_IDLE_BIT] = (s.state == DSQ_IDLE);
  end

  assign any_err = s.frame_err | s.time_err | s.data_err;
  assign cnt_plus = s.conv_cnt + 28'h0000001;

  // whole next state: bus slave first, then the output unit
  always_comb
  begin
    next_s = s;
    start_req = 1'b0;
    clr_req = 1'b0;
    next_s.dac_wr_valid = 1'b0;
    next_s.dac_convert = 1'b0;

    // write address and data are caught independently, in any order
    if (s.awready && s_axi_awvalid)
    begin
      next_s.aw_addr = s_axi_awaddr;
      next_s.awready = 1'b0;
    end
    if (s.wready && s_axi_wvalid)
    begin
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
      next_s.wready = 1'b0;
    end

    // both halves held: perform the write and answer
    if (!s.awready && !s.wready && !s.bvalid)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = DSQ_RESP_OKAY;
      case (s.aw_addr[11:2])
        DSQ_CTRL_OFS[11:2]:
        begin
          if (s.w_strb[0])
          begin
            next_s.enable = s.w_data[DSQ_CTRL_ENABLE_BIT];
            next_s.mode = s.w_data[DSQ_CTRL_MODE_BIT];
            start_req = s.w_data[DSQ_CTRL_START_BIT];
            clr_req = s.w_data[DSQ_CTRL_PRLD_CLR_BIT];
          end
        end
        DSQ_NUMCONV_OFS[11:2]:
        begin
          if (s.w_strb[0])
            next_s.num_conv[7:0] = s.w_data[7:0];
          if (s.w_strb[1])
            next_s.num_conv[15:8] = s.w_data[15:8];
          if (s.w_strb[2])
            next_s.num_conv[23:16] = s.w_data[23:16];
          if (s.w_strb[3])
            next_s.num_conv[27:24] = s.w_data[27:24];
        end
        DSQ_STATUS_OFS[11:2]:
          next_s.bresp = DSQ_RESP_OKAY; // read-only, write ignored
        default:
          next_s.bresp = DSQ_RESP_DECERR;
      endcase
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // read: one outstanding, answered the cycle after the address
    if (s.arready && s_axi_arvalid)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = DSQ_RESP_OKAY;
      case (s_axi_araddr[11:2])
        DSQ_CTRL_OFS[11:2]:
        begin
          next_s.rdata = 32'h00000000;
          next_s.rdata[DSQ_CTRL_ENABLE_BIT] = s.enable;
          next_s.rdata[DSQ_CTRL_MODE_BIT] = s.mode;
        end
        DSQ_STATUS_OFS[11:2]:
          next_s.rdata = status_word;
        DSQ_NUMCONV_OFS[11:2]:
          next_s.rdata = {4'h0, s.num_conv};
        default:
        begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = DSQ_RESP_DECERR;
        end
      endcase
    end
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // dac timing: cycles since the last conversion pulse, saturating
    if (s.spacing != DSQ_MIN_SPACING)
      next_s.spacing = s.spacing + 8'h01;

    if (!s.enable)
    begin
      // disabled: the only way to clear the error flags
      next_s.state = DSQ_IDLE;
      next_s.frame_err = 1'b0;
      next_s.time_err = 1'b0;
      next_s.data_err = 1'b0;
      next_s.active = 1'b0;
      next_s.preloaded = 1'b0;
      next_s.load_idx = 3'h0;
    end
    else
    begin
      // preload: each fifo value goes straight to its dac channel,
      // even before the whole set is in the fifo
      if (fifo_valid && s.fifo_ready)
      begin
        next_s.dac_wr_valid = 1'b1;
        next_s.dac_wr_dev = s.load_idx[2:2];
        next_s.dac_wr_ch = s.load_idx[1:0];
        next_s.dac_wr_data = fifo_data;
        next_s.load_idx = s.load_idx + 3'h1;
        if (s.load_idx == DSQ_LAST_IDX)
          next_s.preloaded = 1'b1;
      end

      case (s.state)
        DSQ_IDLE:
        begin
          // errors keep the unit stopped until it is disabled
          if (!any_err)
          begin
            if (s.mode)
              next_s.state = DSQ_ARMED;
            else if (start_req)
            begin
              next_s.state = DSQ_RUN;
              next_s.active = 1'b1;
              next_s.conv_cnt = 28'h0000000;
            end
          end
        end
        DSQ_ARMED:
        begin
          if (!s.mode)
            next_s.state = DSQ_IDLE;
          else if (frame_trigger)
          begin
            next_s.state = DSQ_RUN;
            next_s.active = 1'b1;
            next_s.conv_cnt = 28'h0000000;
          end
        end
        DSQ_RUN:
        begin
          if (s.mode && frame_trigger && s.num_conv != 28'h0000000)
          begin
            // trigger came before the frame's count was done
            next_s.frame_err = 1'b1;
            next_s.active = 1'b0;
            next_s.state = DSQ_IDLE;
          end
          else if (conv_clk_event)
          begin
            if (s.spacing != DSQ_MIN_SPACING)
            begin
              next_s.time_err = 1'b1;
              next_s.active = 1'b0;
              next_s.state = DSQ_IDLE;
            end
            else if (!s.preloaded)
            begin
              next_s.data_err = 1'b1;
              next_s.active = 1'b0;
              next_s.state = DSQ_IDLE;
            end
            else
            begin
              // one pulse latches every channel of every dac at once
              next_s.dac_convert = 1'b1;
              next_s.preloaded = 1'b0;
              next_s.load_idx = 3'h0;
              next_s.spacing = 8'h00;
              next_s.conv_cnt = cnt_plus;
              if (s.num_conv != 28'h0000000 && cnt_plus == s.num_conv)
              begin
                next_s.active = 1'b0;
                next_s.state = s.mode ? DSQ_ARMED : DSQ_IDLE;
              end
            end
          end
          else if (s.mode && frame_trigger)
            next_s.conv_cnt = 28'h0000000;
        end
        default:
          next_s.state = DSQ_IDLE;
      endcase

      // manual invalidate: the next fifo value refills from channel 0
      if (clr_req)
      begin
        next_s.preloaded = 1'b0;
        next_s.load_idx = 3'h0;
      end
    end

    // stop taking data once loaded, disabled or stopped by an error
    next_s.fifo_ready = next_s.enable && !next_s.preloaded &&
      !(next_s.frame_err || next_s.time_err || next_s.data_err);
  end

  // single register stage for all state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= DSQ_REGS_RESET;
    else
      s <= next_s;
  end

  // outputs come straight from the state flops
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign fifo_ready = s.fifo_ready;
  assign dac_wr_valid = s.dac_wr_valid;
  assign dac_wr_dev = s.dac_wr_dev;
  assign dac_wr_ch = s.dac_wr_ch;
  assign dac_wr_data = s.dac_wr_data;
  assign dac_convert = s.dac_convert;

endmodule

// *** tb/dsq_output_unit_properties.sv ***
// port assertions of the dac sequencer output unit
`timescale 1ns/1ps
module dsq_output_unit_properties
  import dsq_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic conv_clk_event, // clock event
  input wire logic fifo_valid, // fifo valid
  input wire logic [15:0] fifo_data, // fifo value
  input wire logic fifo_ready, // fifo ready
  input wire logic dac_wr_valid, // preload write
  input wire logic [15:0] dac_wr_data, // preload value
  input wire logic dac_convert // conversion pulse
);
  logic [5:0] gap;
  logic [3:0] nwr;
  // cycles and preload writes since the last pulse; both saturate
  always_ff @(posedge aclk)
  begin
    if (!aresetn || dac_convert)
    begin
      gap <= '0;
      nwr <= '0;
    end
    else
    begin
      if (gap != 6'h3F) gap <= gap + 6'h01;
      if (dac_wr_valid && nwr != 4'hF) nwr <= nwr + 4'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_CONV_ALIGN: assert property (
    dac_convert |-> $past(conv_clk_event))
    else $error("pulse without clock event");
  AST_SPACING: assert property (dac_convert |-> gap >= 6'h31)
    else $error("pulses too close");
  AST_PRELOAD: assert property (dac_convert |-> nwr >= 4'h8)
    else $error("pulse without full preload");
  AST_WR_SRC: assert property (
    dac_wr_valid |-> $past(fifo_valid && fifo_ready)
    && dac_wr_data == $past(fifo_data)) else $error("bad preload write");
  AST_CONV_PULSE: assert property (dac_convert |=> !dac_convert)
    else $error("pulse too long");
  AST_B_DROP: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held");
  AST_RD_LAT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  AST_WR_LAT: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write response");
  cover property (dac_convert);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (dac_wr_valid && !fifo_ready);
endmodule

// *** tb/dsq_dac_model.sv ***
// far side: sequencer fifo source and dac preload and output latches
`timescale 1ns/1ps
module dsq_dac_model
  import dsq_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic [7:0] budget, // values offered in all
  output logic fifo_valid, // value offered
  output logic [15:0] fifo_data, // value
  input wire logic fifo_ready, // value taken
  input wire logic dac_wr_valid, // preload write
  input wire logic [0:0] dac_wr_dev, // device
  input wire logic [1:0] dac_wr_ch, // channel
  input wire logic [15:0] dac_wr_data, // value
  input wire logic dac_convert // conversion pulse
);
  logic [7:0] sent;
  logic [15:0] pend [2][4];
  logic [15:0] outv [2][4];
  int nconv;
  // one value every other cycle; a released bus shows the inverse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sent <= '0;
      fifo_valid <= 1'h0;
      fifo_data <= 16'h0000;
    end
    else if (fifo_valid && fifo_ready)
    begin
      sent <= sent + 8'h01;
      fifo_valid <= 1'h0;
      fifo_data <= ~fifo_data;
    end
    else if (!fifo_valid && sent < budget)
    begin
      fifo_valid <= 1'h1;
      fifo_data <= 16'h1000 + 16'(sent);
    end
  end
  // all pending channels reach the outputs together on a pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      nconv <= 0;
    else if (dac_convert)
    begin
      outv <= pend;
      nconv <= nconv + 1;
    end
    if (dac_wr_valid)
      pend[dac_wr_dev][dac_wr_ch] <= dac_wr_data;
  end
endmodule

// *** tb/tb_dac_sequencer_output_status.sv ***
// self-checking bench of the dac sequencer output unit
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
  err_total++; $display("Error %0t: bad value", $time); end end
module tb_dac_sequencer_output_status;
  import dsq_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, cev = 1'h0, ftrig = 1'h0;
  logic awv = 1'h0, wv = 1'h0, brd = 1'h0, arv = 1'h0, rrd = 1'h0;
  logic awr, wr_rdy, bv, arr, rv, fv, fr, dv, cv;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat, st;
  logic [1:0] br, rr, resp, wresp, dch;
  logic [15:0] fd, dd;
  logic [0:0] ddev;
  logic [7:0] budget = '0, per = 8'h3C, ph = '0;
  int err_total = 0, cmp_count = 0, cyc = 0;
  dsq_output_unit i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rrd), .conv_clk_event(cev),
    .frame_trigger(ftrig), .fifo_valid(fv), .fifo_data(fd),
    .fifo_ready(fr), .dac_wr_valid(dv), .dac_wr_dev(ddev),
    .dac_wr_ch(dch), .dac_wr_data(dd), .dac_convert(cv));
  dsq_dac_model i_dac (.aclk(aclk), .aresetn(aresetn), .budget(budget),
    .fifo_valid(fv), .fifo_data(fd), .fifo_ready(fr), .dac_wr_valid(dv),
    .dac_wr_dev(ddev), .dac_wr_ch(dch), .dac_wr_data(dd),
    .dac_convert(cv));
  always #10 aclk = ~aclk;
  task automatic summarize();
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // conversion clock events every per cycles, and the hang limit
  always @(posedge aclk)
  begin
    ph <= (ph >= per - 8'h01) ? 8'h00 : ph + 8'h01;
    cev <= (ph == 8'h00);
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      summarize();
    end
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    brd <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wr_rdy) wv <= 1'h0;
      wresp = br;
    end
    while (!bv);
    brd <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rrd <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
      st = rdat;
      resp = rr;
    end
    while (!rv);
    rrd <= 1'h0;
  endtask
  // poll status until the masked bits match, bounded, then compare
  task automatic wst(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      rd(DSQ_STATUS_OFS);
      n++;
    end
    while ((st & m) !== v && n < 300);
    `CHK(st & m, v)
  endtask
  task automatic wcv();
    int s, n;
    s = i_dac.nconv;
    n = 0;
    while (i_dac.nconv == s && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    // a missing pulse within the wait counts as a mismatch
    `CHK(i_dac.nconv != s, 1'b1)
  endtask
  task automatic trig();
    @(posedge aclk);
    ftrig <= 1'h1;
    @(posedge aclk);
    ftrig <= 1'h0;
  endtask
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rd(DSQ_STATUS_OFS);
    `CHK(st, 32'h1)
    rd(DSQ_NUMCONV_OFS);
    `CHK(st, 32'h0)
    wr(DSQ_NUMCONV_OFS, 32'hFFFFFFFF);
    rd(DSQ_NUMCONV_OFS);
    `CHK(st, 32'h0FFFFFFF)
    rd(12'h2F0);
    `CHK({resp, st}, {DSQ_RESP_DECERR, 32'h0})
    wr(12'h2F0, 32'h1);
    `CHK(wresp, DSQ_RESP_DECERR)
    wr(DSQ_STATUS_OFS, 32'h7F);
    `CHK(wresp, DSQ_RESP_OKAY)
    rd(DSQ_STATUS_OFS);
    `CHK(st, 32'h1)
    budget <= 8'h08;
    wr(DSQ_CTRL_OFS, 32'h1);
    wst(32'h3, 32'h3);
    wr(DSQ_CTRL_OFS, 32'h11);
    rd(DSQ_STATUS_OFS);
    `CHK(st[1], 1'h0)
    budget <= 8'h20;
    wr(DSQ_NUMCONV_OFS, 32'h2);
    // start only once loaded, so the first clock event cannot race it
    wst(32'h2, 32'h2);
    wr(DSQ_CTRL_OFS, 32'h9);
    rd(DSQ_STATUS_OFS);
    `CHK(st & 32'h5, 32'h4)
    rd(DSQ_CTRL_OFS);
    `CHK(st, 32'h1)
    wst(32'h75, 32'h1);
    `CHK(i_dac.nconv, 2)
    `CHK(i_dac.outv[0][0], 16'h1010)
    `CHK(i_dac.outv[1][3], 16'h1017)
    wst(32'h2, 32'h2);
    repeat (150) @(posedge aclk);
    `CHK(i_dac.nconv, 2)
    wr(DSQ_NUMCONV_OFS, 32'h0);
    wr(DSQ_CTRL_OFS, 32'h9);
    wst(32'h75, 32'h11);
    `CHK(i_dac.nconv, 3)
    wr(DSQ_CTRL_OFS, 32'h0);
    rd(DSQ_STATUS_OFS);
    `CHK(st, 32'h1)
    budget <= 8'h30;
    wr(DSQ_CTRL_OFS, 32'h1);
    wst(32'h2, 32'h2);
    per <= 8'h14;
    wr(DSQ_CTRL_OFS, 32'h9);
    wst(32'h75, 32'h21);
    wr(DSQ_CTRL_OFS, 32'h0);
    per <= 8'h3C;
    budget <= 8'hFF;
    wr(DSQ_NUMCONV_OFS, 32'h3);
    wr(DSQ_CTRL_OFS, 32'h5);
    rd(DSQ_CTRL_OFS);
    `CHK(st, 32'h5)
    wst(32'h3, 32'h2);
    trig();
    wcv();
    rd(DSQ_STATUS_OFS);
    `CHK(st[2], 1'h1)
    trig();
    wst(32'h75, 32'h41);
    wr(DSQ_CTRL_OFS, 32'h0);
    wr(DSQ_NUMCONV_OFS, 32'h0);
    wr(DSQ_CTRL_OFS, 32'h5);
    wst(32'h3, 32'h2);
    trig();
    wcv();
    trig();
    wcv();
    rd(DSQ_STATUS_OFS);
    `CHK(st & 32'h75, 32'h4)
    wr(DSQ_CTRL_OFS, 32'h0);
    wr(DSQ_NUMCONV_OFS, 32'h1);
    wr(DSQ_CTRL_OFS, 32'h5);
    wst(32'h3, 32'h2);
    trig();
    wcv();
    wst(32'h75, 32'h0);
    summarize();
  end
endmodule
bind dsq_output_unit dsq_output_unit_properties i_chk (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .conv_clk_event(conv_clk_event),
  .fifo_valid(fifo_valid), .fifo_data(fifo_data),
  .fifo_ready(fifo_ready), .dac_wr_valid(dac_wr_valid),
  .dac_wr_data(dac_wr_data), .dac_convert(dac_convert));
